//--- src/sbc_mode_control.sv
`timescale 1ns/1ps
`include "sbc_mode_defs.svh"

// Function
// (RQ1) Frame header bits 15:13 equal to 001 select this register.
// (RQ2) Header bit 12 set returns content only; clear writes control bits.
// (RQ3) Mode field 11:10: standby, sleep, normal supply off, normal supply on; resets 00.
// (RQ4) Every reset forces the fail-safe warning bit to one.
// (RQ5) Warning set means next reset activates fail-safe output; writing zero disarms. The code does this on sys_reset only; rst clears the output.
// (RQ6) On reset fail-safe control becomes the warning bit held before reset. The code does this on sys_reset only; rst loads zero.
// (RQ7) Fail-safe control bit 8 pulls the output low when one, floats otherwise.
// (RQ8) Aux enable bit 7 drives output high only in a normal mode.
// (RQ9) LIN slope bit 6: zero normal 20 kbit/s, one low 10.4 kbit/s.
// (RQ10) Sampling off: wake bias bit floats the bias pin or drives it low.
// (RQ11) Sampling on: wake bias bit picks 16 ms or 64 ms sampling period.
// (RQ12) Pass transistor bit 4 picks 85/50 mA or 50/15 mA thresholds.
// (RQ13) Reserved bits 3:0 read as zero and ignore writes.
module sbc_mode_control #(
  parameter int unsigned SAMPLE_SHORT_CYCLES = `WAKE_SAMPLE_SHORT_MS * `CLK_KHZ,
  parameter int unsigned SAMPLE_LONG_CYCLES  = `WAKE_SAMPLE_LONG_MS * `CLK_KHZ
) (
  // Clock and resets
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  sys_reset,
  // Serial port
  input  wire logic                  scs_n,
  input  wire logic                  sck,
  input  wire logic                  sdi,
  output logic                       sdo_o,
  output logic                       sdo_oe,
  // Wake input sampling
  input  wire logic                  wake_sample_on,
  output logic                       wake_sample_tick,
  output logic                       wake_bias_pin_o,
  output logic                       wake_bias_pin_oe,
  // Controls
  output sbc_mode_pkg::op_mode_t     operating_mode_select,
  output logic                       transceiver_supply_rail_on,
  output logic                       fail_safe_o,
  output logic                       fail_safe_oe,
  output logic                       aux_output,
  output logic                       lin_slew_select,
  output logic                       pass_transistor_threshold_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  sbc_mode_pkg::op_mode_t mode_reg, mode_next;
  logic ro_reg, ro_next;
  logic fail_safe_warning_arm_reg, fail_safe_warning_arm_next;
  logic lhc_reg, lhc_next;
  logic enc_reg, enc_next;
  logic lsc_reg, lsc_next;
  logic wbc_reg, wbc_next;
  logic pdc_reg, pdc_next;

  // Serial state
  logic                      scs_n_d_reg, scs_n_d_next;
  logic                      sck_d_reg, sck_d_next;
  logic [`FRAME_BITS-1:0]    rx_reg, rx_next;
  logic [`FRAME_BITS-1:0]    tx_reg, tx_next;
  logic [`FRAME_CNT_W-1:0]   cnt_reg, cnt_next;
  logic                      sdo_o_next, sdo_oe_next;

  // Pin and sampling state
  logic [`WAKE_CNT_W-1:0]    wcnt_reg, wcnt_next;
  logic                      tick_next;
  logic                      tsr_next, fs_oe_next, aux_next, wb_oe_next;

  logic [`FRAME_BITS-1:0]    content;
  logic                      frame_end;
  logic                      is_normal;
  logic [`WAKE_CNT_W-1:0]    period_last;

  function automatic logic is_normal_mode(input sbc_mode_pkg::op_mode_t m);
    is_normal_mode = m[1];
  endfunction

  assign content = {`ADDR_THIS, ro_reg, mode_reg, fail_safe_warning_arm_reg, lhc_reg, enc_reg,
                    lsc_reg, wbc_reg, pdc_reg, {`RESV_W{1'b0}}}; // see RQ13
  assign frame_end = ~scs_n_d_reg & scs_n;
  assign is_normal = is_normal_mode(mode_reg);
  assign period_last = wbc_reg ? `WAKE_CNT_W'(SAMPLE_LONG_CYCLES - 1)
                               : `WAKE_CNT_W'(SAMPLE_SHORT_CYCLES - 1); // see RQ11

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame and register update
  always_comb
  begin
    scs_n_d_next = scs_n;
    sck_d_next   = sck;
    rx_next      = rx_reg;
    tx_next      = tx_reg;
    cnt_next     = cnt_reg;
    sdo_o_next   = sdo_o;
    sdo_oe_next  = ~scs_n;
    mode_next    = mode_reg;
    ro_next      = ro_reg;
    fail_safe_warning_arm_next    = fail_safe_warning_arm_reg;
    lhc_next     = lhc_reg;
    enc_next     = enc_reg;
    lsc_next     = lsc_reg;
    wbc_next     = wbc_reg;
    pdc_next     = pdc_reg;
    if (scs_n_d_reg & ~scs_n)
    begin
      // Frame start: old content goes out while new bits come in
      tx_next    = {content[`FRAME_BITS-2:0], 1'b0};
      sdo_o_next = content[`FRAME_BITS-1];
      cnt_next   = '0;
    end
    else if (~scs_n)
    begin
      if (sck_d_reg & ~sck)
      begin
        rx_next  = {rx_reg[`FRAME_BITS-2:0], sdi};
        cnt_next = cnt_reg + `FRAME_CNT_W'(1);
      end
      else if (~sck_d_reg & sck & (cnt_reg != '0))
      begin
        sdo_o_next = tx_reg[`FRAME_BITS-1];
        tx_next    = {tx_reg[`FRAME_BITS-2:0], 1'b0};
      end
    end
    if (frame_end & (cnt_reg == `FRAME_CNT_W'(`FRAME_BITS))
        & (rx_reg[`ADDR_MSB:`ADDR_LSB] == `ADDR_THIS)) // see RQ1
    begin
      ro_next = rx_reg[`RO_BIT];
      if (~rx_reg[`RO_BIT]) // see RQ2
      begin
        mode_next = sbc_mode_pkg::op_mode_t'(rx_reg[`MODE_MSB:`MODE_LSB]); // see RQ3
        fail_safe_warning_arm_next = rx_reg[`FAIL_SAFE_WARNING_ARM_BIT]; // see RQ5
        lhc_next  = rx_reg[`LHC_BIT];
        enc_next  = rx_reg[`ENC_BIT];
        lsc_next  = rx_reg[`LSC_BIT];
        wbc_next  = rx_reg[`WBC_BIT];
        pdc_next  = rx_reg[`PDC_BIT];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    scs_n_d_reg <= scs_n_d_next;
    sck_d_reg   <= sck_d_next;
    rx_reg      <= rx_next;
    tx_reg      <= tx_next;
    cnt_reg     <= cnt_next;
    if (rst)
    begin
      scs_n_d_reg <= 1'b1;
      sck_d_reg   <= 1'b0;
      cnt_reg     <= '0;
      sdo_o       <= 1'b0;
      sdo_oe      <= 1'b0;
      mode_reg    <= sbc_mode_pkg::op_mode_t'(`MODE_RST);
      ro_reg      <= `CTL_RST;
      fail_safe_warning_arm_reg    <= `FAIL_SAFE_WARNING_ARM_RST; // see RQ4
      lhc_reg     <= `CTL_RST;
      enc_reg     <= `CTL_RST;
      lsc_reg     <= `CTL_RST; // see RQ9
      wbc_reg     <= `CTL_RST;
      pdc_reg     <= `CTL_RST;
    end
    else if (sys_reset)
    begin
      cnt_reg     <= '0;
      sdo_o       <= 1'b0;
      sdo_oe      <= 1'b0;
      mode_reg    <= sbc_mode_pkg::op_mode_t'(`MODE_RST);
      ro_reg      <= `CTL_RST;
      fail_safe_warning_arm_reg    <= `FAIL_SAFE_WARNING_ARM_RST; // see RQ4
      lhc_reg     <= fail_safe_warning_arm_reg; // see RQ5, RQ6
      enc_reg     <= `CTL_RST;
      lsc_reg     <= `CTL_RST;
      wbc_reg     <= `CTL_RST;
      pdc_reg     <= `CTL_RST;
    end
    else
    begin
      sdo_o       <= sdo_o_next;
      sdo_oe      <= sdo_oe_next;
      mode_reg    <= mode_next;
      ro_reg      <= ro_next;
      fail_safe_warning_arm_reg    <= fail_safe_warning_arm_next;
      lhc_reg     <= lhc_next;
      enc_reg     <= enc_next;
      lsc_reg     <= lsc_next;
      wbc_reg     <= wbc_next;
      pdc_reg     <= pdc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and wake sampling
  always_comb
  begin
    wcnt_next  = '0;
    tick_next  = 1'b0;
    if (wake_sample_on)
    begin
      if (wcnt_reg >= period_last)
        tick_next = 1'b1;
      else
        wcnt_next = wcnt_reg + `WAKE_CNT_W'(1);
    end
    tsr_next   = (mode_reg == sbc_mode_pkg::MODE_NORMAL);
    fs_oe_next = lhc_reg; // see RQ7
    aux_next   = enc_reg & is_normal; // see RQ8
    wb_oe_next = wbc_reg & ~wake_sample_on; // see RQ10
  end

  always_ff @(posedge mclk)
  begin
    if (rst | sys_reset)
    begin
      wcnt_reg                         <= '0;
      wake_sample_tick                 <= 1'b0;
      transceiver_supply_rail_on       <= 1'b0;
      fail_safe_oe                     <= (~rst) & fail_safe_warning_arm_reg; // see RQ6
      aux_output                       <= 1'b0;
      wake_bias_pin_oe                 <= 1'b0;
      lin_slew_select                  <= 1'b0;
      pass_transistor_threshold_select <= 1'b0;
      operating_mode_select            <= sbc_mode_pkg::op_mode_t'(`MODE_RST);
    end
    else
    begin
      wcnt_reg                         <= wcnt_next;
      wake_sample_tick                 <= tick_next;
      transceiver_supply_rail_on       <= tsr_next;
      fail_safe_oe                     <= fs_oe_next;
      aux_output                       <= aux_next;
      wake_bias_pin_oe                 <= wb_oe_next;
      lin_slew_select                  <= lsc_reg; // see RQ9
      pass_transistor_threshold_select <= pdc_reg; // see RQ12
      operating_mode_select            <= mode_reg; // see RQ3
    end
  end

  // Open-drain pins only ever pull low
  always_ff @(posedge mclk)
  begin
    fail_safe_o     <= 1'b0;
    wake_bias_pin_o <= 1'b0;
  end

endmodule

//--- inc/sbc_mode_defs.svh
`ifndef SBC_MODE_DEFS_SVH
`define SBC_MODE_DEFS_SVH

// Clock rate
`define CLK_KHZ            125000

// Frame layout
`define FRAME_BITS         16
`define FRAME_CNT_W        5
`define ADDR_MSB           15
`define ADDR_LSB           13
`define ADDR_THIS          3'h1
`define RO_BIT             12
`define MODE_MSB           11
`define MODE_LSB           10
`define FAIL_SAFE_WARNING_ARM_BIT           9
`define LHC_BIT            8
`define ENC_BIT            7
`define LSC_BIT            6
`define WBC_BIT            5
`define PDC_BIT            4
`define RESV_W             4

// Reset values
`define MODE_RST           2'h0
`define FAIL_SAFE_WARNING_ARM_RST           1'h1
`define CTL_RST            1'h0

// Wake sampling periods
`define WAKE_SAMPLE_SHORT_MS 16
`define WAKE_SAMPLE_LONG_MS  64
`define WAKE_CNT_W         23

`endif

//--- inc/sbc_mode_pkg.sv
package sbc_mode_pkg;

  typedef enum logic [1:0] {
    MODE_STANDBY   = 2'b00,
    MODE_SLEEP     = 2'b01,
    MODE_NORMAL_V2 = 2'b10,
    MODE_NORMAL    = 2'b11
  } op_mode_t;

endpackage

//--- dv/sbc_mode_control_checker.sv
`timescale 1ns/1ps
module sbc_mode_control_checker #(
  parameter int unsigned SAMPLE_SHORT_CYCLES = 20,
  parameter int unsigned SAMPLE_LONG_CYCLES  = 80
) (
  // Clock and resets
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic                   sys_reset,
  // Serial and wake
  input wire logic                   scs_n,
  input wire logic                   sdo_oe,
  input wire logic                   wake_sample_on,
  input wire logic                   wake_sample_tick,
  input wire logic                   wake_bias_pin_oe,
  // Controls
  input wire sbc_mode_pkg::op_mode_t operating_mode_select,
  input wire logic                   transceiver_supply_rail_on,
  input wire logic                   fail_safe_oe,
  input wire logic                   aux_output,
  input wire logic                   lin_slew_select,
  input wire logic                   pass_transistor_threshold_select
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // No frame end and no system reset lately
  sequence quiet;
    (scs_n && !sys_reset)[*5];
  endsequence
  a_aux_normal:
    assert property (aux_output |-> operating_mode_select[1]) else $error("aux high off normal");
  a_supply_mode:
    assert property (transceiver_supply_rail_on == (operating_mode_select == 2'h3))
    else $error("supply rail disagrees with mode");
  a_por_defaults:
    assert property ($fell(rst) |-> operating_mode_select == 2'h0 && !fail_safe_oe)
    else $error("bad power-on outputs");
  a_bias_sampling:
    assert property (wake_bias_pin_oe |-> !$past(wake_sample_on)) else $error("bias pin driven");
  a_tick_off:
    assert property (!wake_sample_on [*2] |-> !wake_sample_tick) else $error("tick while off");
  a_tick_gap:
    assert property (wake_sample_tick |=> !wake_sample_tick [*8]) else $error("ticks too close");
  a_sdo_select:
    assert property (1'b1 |=> sdo_oe == !$past(scs_n)) else $error("sdo enable wrong");
  a_ctl_hold:
    assert property (quiet |-> $stable({fail_safe_oe, lin_slew_select,
      pass_transistor_threshold_select})) else $error("control changed without write");
endmodule

//--- dv/sbc_spi_host.sv
`timescale 1ns/1ps
module sbc_spi_host (
  // Clock
  input wire logic mclk,
  // Serial lines
  output logic     scs_n,
  output logic     sck,
  output logic     sdi,
  input wire logic sdo_o
);
  initial
  begin
    scs_n = 1'b1;
    sck   = 1'b0;
    sdi   = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Full-duplex frame, MSB first; sdi moves on the sck rise, both ends sample on the fall
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    step(1);
    scs_n = 1'b0;
    step(2);
    for (int i = 15; i >= 0; i--)
    begin
      sck = 1'b1;
      sdi = tx[i];
      step(2);
      rx[i] = sdo_o;
      sck = 1'b0;
      step(2);
    end
    scs_n = 1'b1;
    sdi   = ~sdi;
    step(4);
  endtask
endmodule

//--- dv/sbc_mode_control_tb.sv
`timescale 1ns/1ps
module sbc_mode_control_tb;
  localparam int SHORT = 20;
  localparam int LONG  = 80;
  typedef struct packed {logic [15:0] tx; logic [2:0] outs;} row_t;
  logic                   mclk, rst, sys_reset, wake_sample_on, scs_n, sck, sdi, sdo_o, sdo_oe;
  logic                   wake_sample_tick, wake_bias_pin_o, wake_bias_pin_oe, fail_safe_o;
  logic                   fail_safe_oe, aux_output, lin_slew_select, transceiver_supply_rail_on;
  logic                   pass_transistor_threshold_select;
  sbc_mode_pkg::op_mode_t operating_mode_select;
  logic [15:0]            rx;
  int                     err_total, num_checks, n;
  row_t                   rows [4] = '{'{16'h2FDF, 3'h7}, '{16'h28A5, 3'h4},
                                       '{16'h24D0, 3'h0}, '{16'h2220, 3'h0}};
  sbc_mode_control #(.SAMPLE_SHORT_CYCLES(SHORT), .SAMPLE_LONG_CYCLES(LONG)) DUT (.mclk, .rst,
    .sys_reset, .scs_n, .sck, .sdi, .sdo_o, .sdo_oe, .wake_sample_on, .wake_sample_tick,
    .wake_bias_pin_o, .wake_bias_pin_oe, .operating_mode_select, .transceiver_supply_rail_on,
    .fail_safe_o, .fail_safe_oe, .aux_output, .lin_slew_select, .pass_transistor_threshold_select);
  sbc_spi_host host (.mclk, .scs_n, .sck, .sdi, .sdo_o);
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [15:0] e);
    host.xfer(16'h3000, rx);
    rx[12] = 1'b0;
    chk("readback", e, rx);
  endtask
  task automatic pulse;
    sys_reset = 1'b1;
    host.step(1);
    sys_reset = 1'b0;
    host.step(3);
  endtask
  // Cycles from one sampling tick to the next
  task automatic gap;
    n = 0;
    while (!wake_sample_tick && n < 200)
    begin
      host.step(1);
      n++;
    end
    n = 0;
    host.step(1);
    while (!wake_sample_tick && n < 200)
    begin
      host.step(1);
      n++;
    end
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", err_total, num_checks);
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    #200000;
    err_total++;
    conclude;
  end
  initial
  begin
    rst = 1'b1;
    sys_reset = 1'b0;
    wake_sample_on = 1'b0;
    err_total = 0;
    num_checks = 0;
    host.step(10);
    rst = 1'b0;
    rd(16'h2200);
    foreach (rows[i])
    begin
      host.xfer(rows[i].tx, rx);
      rd({3'h1, 1'b0, rows[i].tx[11:4], 4'h0});
      chk("outputs", {9'h0, rows[i].tx[11:10], rows[i].outs, rows[i].tx[6], rows[i].tx[4]},
        {9'h0, operating_mode_select, aux_output, transceiver_supply_rail_on, fail_safe_oe,
        lin_slew_select, pass_transistor_threshold_select});
    end
    host.xfer(16'h5FF0, rx);
    host.xfer(16'h3FF0, rx);
    rd(16'h2220);
    pulse;
    chk("fail_oe", 16'h1, {15'h0, fail_safe_oe});
    rd(16'h2300);
    chk("fail_pin", 16'h0, {15'h0, fail_safe_o});
    host.xfer(16'h2020, rx);
    pulse;
    chk("fail_oe", 16'h0, {15'h0, fail_safe_oe});
    host.xfer(16'h2020, rx);
    chk("bias_oe", 16'h1, {15'h0, wake_bias_pin_oe});
    chk("bias_pin", 16'h0, {15'h0, wake_bias_pin_o});
    chk("sdo_oe", 16'h0, {15'h0, sdo_oe});
    wake_sample_on = 1'b1;
    host.step(2);
    chk("bias_oe", 16'h0, {15'h0, wake_bias_pin_oe});
    gap;
    chk("long_period", LONG[15:0], 16'(n + 1));
    host.xfer(16'h2000, rx);
    gap;
    chk("short_period", SHORT[15:0], 16'(n + 1));
    // Power-on reset clears fail-safe control even with the warning armed
    host.xfer(16'h2300, rx);
    rst = 1'b1;
    host.step(2);
    rst = 1'b0;
    host.step(2);
    chk("por_fail_oe", 16'h0, {15'h0, fail_safe_oe});
    rd(16'h2200);
    conclude;
  end
endmodule
bind sbc_mode_control sbc_mode_control_checker #(.SAMPLE_SHORT_CYCLES(SAMPLE_SHORT_CYCLES),
  .SAMPLE_LONG_CYCLES(SAMPLE_LONG_CYCLES)) u_chk (.mclk, .rst, .sys_reset, .scs_n, .sdo_oe,
  .wake_sample_on, .wake_sample_tick, .wake_bias_pin_oe, .operating_mode_select,
  .transceiver_supply_rail_on, .fail_safe_oe, .aux_output, .lin_slew_select,
  .pass_transistor_threshold_select);
